/* hdl/ssr_pkg.sv */
package ssr_pkg;
	// Register byte offsets on the configuration port
	localparam logic [7:0] ADDR_LOSS_STATUS  = 8'h29;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h2A;
	localparam logic [7:0] ADDR_BIT_ORDER    = 8'h2E;
	localparam logic [7:0] ADDR_CLK_DELAY    = 8'h30;

	// Field positions
	localparam int CLK_LOSS_BIT   = 5;
	localparam int LANE_LOSS_LSB  = 0;
	localparam int CLK_DETECT_BIT = 3;
	localparam int PLL_LOCK_BIT   = 2;
	localparam int REVERSE_BIT    = 6;
	localparam int DELAY_LSB      = 5;

	// Reset values
	localparam logic       REVERSE_RST = 1'h0;
	localparam logic [2:0] DELAY_RST   = 3'h3;

	// Delay step in picoseconds per code increment
	localparam int DELAY_STEP_PS = 125;

	// Nominal delay figure after reset
	localparam logic [11:0] DELAY_PS_RST =
		12'(32'(DELAY_RST) * DELAY_STEP_PS);

	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} ssr_req_t;

	typedef struct packed {
		logic       clockLossFlag;
		logic [4:0] laneDataLossFlags;
		logic       inputClockDetectFlag;
		logic       pllLocked;
	} ssr_status_t;
endpackage

/* hdl/ssr_status_tuning_regs.sv */
// Functional notes
// - Bit 5 reads 1 when input clock absent
// - Bits 4:0 flag per-lane data loss
// - Event bit 3 shows input clock detected
// - Event bit 2 shows PLL locked
// - Bit-order bit 6 reverses serialization order
// - Delay code bits 7:5, reset 011
// - Each delay code step adds 125 ps
`timescale 1ns/100ps
module ssr_status_tuning_regs
#(
	parameter int LANES = 5
)
(
	input  wire logic               core_clk,   // 100 MHz clock
	input  wire logic               reset_n,    // Async reset, active low
	input  wire ssr_pkg::ssr_req_t  req,        // Register access request
	input  wire ssr_pkg::ssr_status_t status,   // Live status inputs
	output logic [7:0]              rdData,     // Read data, registered
	output logic                    rdValid,    // Read data valid pulse
	output logic                    reverseBitOrder, // Reverse serial order
	output logic [2:0]              inputClockDelayCode, // Delay tap select
	output logic [11:0]             inputClockDelayPs    // Nominal delay
);
	logic       reverse_r;
	logic       reverse_nxt;
	logic [2:0] delay_r;
	logic [2:0] delay_nxt;
	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;
	logic       rdValid_r;
	logic       rdValid_nxt;
	logic [7:0] lossByte;
	logic [7:0] eventByte;
	logic [11:0] delayPs_r;
	logic [11:0] delayPs_nxt;

	always_comb
	begin
		lossByte = 8'h00;
		lossByte[ssr_pkg::CLK_LOSS_BIT] = status.clockLossFlag;
		lossByte[ssr_pkg::LANE_LOSS_LSB +: LANES] =
			status.laneDataLossFlags[LANES-1:0];
		eventByte = 8'h00;
		eventByte[ssr_pkg::CLK_DETECT_BIT] =
			status.inputClockDetectFlag;
		eventByte[ssr_pkg::PLL_LOCK_BIT] = status.pllLocked;
	end

	always_comb
	begin
		reverse_nxt = reverse_r;
		delay_nxt   = delay_r;
		// Only the writable fields latch; everything else drops
		if (req.wrEn && req.addr == ssr_pkg::ADDR_BIT_ORDER)
			reverse_nxt = req.wrData[ssr_pkg::REVERSE_BIT];
		if (req.wrEn && req.addr == ssr_pkg::ADDR_CLK_DELAY)
			delay_nxt = req.wrData[ssr_pkg::DELAY_LSB +: 3];
		// Figure taken from the next code so it never lags the code
		delayPs_nxt =
			12'(32'(delay_nxt) * ssr_pkg::DELAY_STEP_PS);
		// Status is sampled in the cycle of the read; no snapshot is held
		rdValid_nxt = req.rdEn;
		rdData_nxt  = 8'h00;
		if (req.rdEn)
		begin
			unique case (req.addr)
				ssr_pkg::ADDR_LOSS_STATUS:  rdData_nxt = lossByte;
				ssr_pkg::ADDR_EVENT_STATUS: rdData_nxt = eventByte;
				ssr_pkg::ADDR_BIT_ORDER:
					rdData_nxt[ssr_pkg::REVERSE_BIT] = reverse_r;
				ssr_pkg::ADDR_CLK_DELAY:
					rdData_nxt[ssr_pkg::DELAY_LSB +: 3] = delay_r;
				default:                    rdData_nxt = 8'h00;
			endcase
		end
	end

	// Read data drops to zero between reads, so a host that ignores
	// rdValid cannot take a stale byte for a fresh one
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reverse_r <= ssr_pkg::REVERSE_RST;
			delay_r   <= ssr_pkg::DELAY_RST;
			delayPs_r <= ssr_pkg::DELAY_PS_RST;
			rdData_r  <= 8'h00;
			rdValid_r <= 1'h0;
		end
		else
		begin
			reverse_r <= reverse_nxt;
			delay_r   <= delay_nxt;
			delayPs_r <= delayPs_nxt;
			rdData_r  <= rdData_nxt;
			rdValid_r <= rdValid_nxt;
		end
	end

	// binds the host: reversal is honoured in every mode, so a wrong
	// mode gives wrong output rather than a silent block here.
	assign reverseBitOrder     = reverse_r;
	assign inputClockDelayCode = delay_r;
	assign inputClockDelayPs   = delayPs_r;
	assign rdData  = rdData_r;
	assign rdValid = rdValid_r;

	property p_clkLoss;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rdEn && req.addr == ssr_pkg::ADDR_LOSS_STATUS)
			|=> rdData[5] == $past(status.clockLossFlag);
	endproperty
	a_clkLoss: assert property (p_clkLoss)
		else $error("clock loss bad");

	property p_laneLoss;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rdEn && req.addr == ssr_pkg::ADDR_LOSS_STATUS)
			|=> rdData[4:0] == $past(status.laneDataLossFlags)
				&& rdData[7:6] == 2'h0;
	endproperty
	a_laneLoss: assert property (p_laneLoss)
		else $error("lane loss bad");

	property p_detect;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rdEn && req.addr == ssr_pkg::ADDR_EVENT_STATUS)
			|=> rdData[3] == $past(status.inputClockDetectFlag);
	endproperty
	a_detect: assert property (p_detect)
		else $error("detect bad");

	property p_lock;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rdEn && req.addr == ssr_pkg::ADDR_EVENT_STATUS)
			|=> rdData[2] == $past(status.pllLocked)
				&& rdData[1:0] == 2'h0 && rdData[7:4] == 4'h0;
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock bad");

	property p_reverse;
		@(posedge core_clk) disable iff (!reset_n)
		(req.wrEn && req.addr == ssr_pkg::ADDR_BIT_ORDER)
			|=> reverseBitOrder == $past(req.wrData[6]);
	endproperty
	a_reverse: assert property (p_reverse)
		else $error("reverse bad");

	property p_delay;
		@(posedge core_clk) disable iff (!reset_n)
		(req.wrEn && req.addr == ssr_pkg::ADDR_CLK_DELAY)
			|=> inputClockDelayCode == $past(req.wrData[7:5]);
	endproperty
	a_delay: assert property (p_delay)
		else $error("delay bad");

	property p_delayPs;
		@(posedge core_clk) disable iff (!reset_n)
		inputClockDelayPs == 12'(inputClockDelayCode) * 12'h07D;
	endproperty
	a_delayPs: assert property (p_delayPs)
		else $error("step bad");

	property p_roIgnored;
		@(posedge core_clk) disable iff (!reset_n)
		(req.wrEn && req.addr != ssr_pkg::ADDR_BIT_ORDER
			&& req.addr != ssr_pkg::ADDR_CLK_DELAY)
			|=> $stable(reverseBitOrder) && $stable(inputClockDelayCode);
	endproperty
	a_roIgnored: assert property (p_roIgnored)
		else $error("ro write");

	// Reserved bits of the writable registers must read back as zero
	property p_orderRead;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rdEn && req.addr == ssr_pkg::ADDR_BIT_ORDER)
			|=> rdData == {1'h0, $past(reverseBitOrder), 6'h00};
	endproperty
	a_orderRead: assert property (p_orderRead)
		else $error("bit order read bad");

	property p_delayRead;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rdEn && req.addr == ssr_pkg::ADDR_CLK_DELAY)
			|=> rdData == {$past(inputClockDelayCode), 5'h00};
	endproperty
	a_delayRead: assert property (p_delayRead)
		else $error("delay read bad");

	property p_unmappedRead;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rdEn && req.addr != ssr_pkg::ADDR_LOSS_STATUS
			&& req.addr != ssr_pkg::ADDR_EVENT_STATUS
			&& req.addr != ssr_pkg::ADDR_BIT_ORDER
			&& req.addr != ssr_pkg::ADDR_CLK_DELAY)
			|=> rdData == 8'h00;
	endproperty
	a_unmappedRead: assert property (p_unmappedRead)
		else $error("unmapped read bad");

	// Checked at the first edge after release, before any write lands
	property p_resetValues;
		@(posedge core_clk) disable iff (!reset_n)
		$rose(reset_n) |-> reverseBitOrder == ssr_pkg::REVERSE_RST
			&& inputClockDelayCode == ssr_pkg::DELAY_RST;
	endproperty
	a_resetValues: assert property (p_resetValues)
		else $error("reset value bad");

	// Main scenarios the bench is meant to reach
	c_revWrite: cover property (@(posedge core_clk)
		req.wrEn && req.addr == ssr_pkg::ADDR_BIT_ORDER && req.wrData[6]);
	c_delayMax: cover property (@(posedge core_clk)
		inputClockDelayCode == 3'h7);
	c_lossRead: cover property (@(posedge core_clk)
		rdValid && rdData[5]);
	c_eventRead: cover property (@(posedge core_clk)
		rdValid && rdData[3]);
	c_delayMin: cover property (@(posedge core_clk)
		inputClockDelayCode == 3'h0);
endmodule

/* sim/ssr_host_model.sv */
`timescale 1ns/100ps
module ssr_host_model
(
	input  wire logic         core_clk, // Block clock
	output ssr_pkg::ssr_req_t req       // Request to the block
);
	initial req = '0;
	// One access per call, idle cycle after it so strobes never merge
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(negedge core_clk);
		req <= '{w, !w, a, d};
		@(negedge core_clk);
		req <= '0;
	endtask
endmodule

/* sim/ssr_status_tuning_regs_tb_top.sv */
`timescale 1ns/100ps
module ssr_status_tuning_regs_tb_top;
	logic                 core_clk = 1'b0;
	logic                 reset_n  = 1'b0;
	ssr_pkg::ssr_req_t    req;
	ssr_pkg::ssr_status_t status   = '0;
	logic [7:0]           rdData;
	logic                 rdValid;
	logic                 reverseBitOrder;
	logic [2:0]           code;
	logic [11:0]          ps;
	int                   num_errors = 0;
	int                   checks     = 0;
	always #5 core_clk = ~core_clk;
	ssr_host_model i_host (.core_clk(core_clk), .req(req));
	ssr_status_tuning_regs i_dut
	(
		.core_clk(core_clk),
		.reset_n(reset_n),
		.req(req),
		.status(status),
		.rdData(rdData),
		.rdValid(rdValid),
		.reverseBitOrder(reverseBitOrder),
		.inputClockDelayCode(code),
		.inputClockDelayPs(ps)
	);
	task automatic chk(input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, exp);
		i_host.acc(1'b0, a, 8'h00);
		chk({7'h00, rdValid, rdData}, {7'h00, 1'b1, exp});
		// Read data stands for one cycle only, then drops to zero
		@(negedge core_clk);
		chk({7'h00, rdValid, rdData}, 16'h0000);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Whole run needs well under 200 cycles
	initial
	begin
		#20000;
		num_errors++;
		conclude;
	end
	initial
	begin
		repeat (8) @(negedge core_clk);
		reset_n = 1'b1;
		// Reset: normal order, code 3, 375 ps
		chk({reverseBitOrder, code, ps}, 16'h3177);
		rd(ssr_pkg::ADDR_CLK_DELAY, 8'h60);
		status = '{1'b1, 5'h15, 1'b0, 1'b1};
		rd(ssr_pkg::ADDR_LOSS_STATUS, 8'h35);
		rd(ssr_pkg::ADDR_EVENT_STATUS, 8'h04);
		status = '{1'b0, 5'h0A, 1'b1, 1'b0};
		rd(ssr_pkg::ADDR_LOSS_STATUS, 8'h0A);
		rd(ssr_pkg::ADDR_EVENT_STATUS, 8'h08);
		i_host.acc(1'b1, ssr_pkg::ADDR_LOSS_STATUS, 8'hFF);
		rd(ssr_pkg::ADDR_LOSS_STATUS, 8'h0A);
		i_host.acc(1'b1, ssr_pkg::ADDR_EVENT_STATUS, 8'hFF);
		rd(ssr_pkg::ADDR_EVENT_STATUS, 8'h08);
		chk({reverseBitOrder, code, ps}, 16'h3177);
		$display("status test done");
		// Reversal written with no mode condition; the block has no serializer mode input
		i_host.acc(1'b1, ssr_pkg::ADDR_BIT_ORDER, 8'hFF);
		chk({15'h0000, reverseBitOrder}, 16'h0001);
		rd(ssr_pkg::ADDR_BIT_ORDER, 8'h40);
		i_host.acc(1'b1, ssr_pkg::ADDR_BIT_ORDER, 8'hBF);
		chk({15'h0000, reverseBitOrder}, 16'h0000);
		rd(8'h2F, 8'h00);
		$display("bit order test done");
		for (int c = 0; c < 8; c++)
		begin
			i_host.acc(1'b1, ssr_pkg::ADDR_CLK_DELAY, {3'(c), 5'h1F});
			chk({1'b0, code, ps},
				{1'b0, 3'(c), 12'(c) * 12'h07D});
			rd(ssr_pkg::ADDR_CLK_DELAY, {3'(c), 5'h00});
		end
		$display("delay test done");
		// Reset in mid-run must restore both tuning fields
		i_host.acc(1'b1, ssr_pkg::ADDR_BIT_ORDER, 8'h40);
		chk({15'h0000, reverseBitOrder}, 16'h0001);
		reset_n = 1'b0;
		@(negedge core_clk);
		reset_n = 1'b1;
		chk({reverseBitOrder, code, ps}, 16'h3177);
		rd(ssr_pkg::ADDR_BIT_ORDER, 8'h00);
		rd(ssr_pkg::ADDR_CLK_DELAY, 8'h60);
		$display("reset test done");
		conclude;
	end
endmodule
